// File: logic/lpm_ctrl.sv
// Low power mode controller with classic Wishbone register slave
//
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "lpm_params.svh"

module lpm_ctrl #(
  parameter int IRQ_N = `LPM_IRQ_N,
  parameter int TICK_N = 8
) (
  input wire logic clk_i, // 40 MHz system clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [`LPM_ADR_W-1:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic [IRQ_N-1:0] irq_pend_i, // Pending interrupt latches
  input wire logic wdt_irq_i, // Watchdog interrupt pending
  input wire logic [TICK_N-1:0] tick_src_i, // Tick source clocks, async
  input wire logic [`LPM_PC_W-1:0] start_addr_i, // Address of current instruction
  output lpm_pkg::lpm_pwr_t pwr_o, // Clock and stall controls
  output lpm_pkg::lpm_osc_t osc_o, // Oscillator controls
  output logic [`LPM_PC_W-1:0] resume_pc_o, // Held program counter
  output logic vector_o, // Interrupt service request pulse
  output logic tick_irq_set_o // Tick pending latch set pulse
);
  import lpm_pkg::*;

  localparam int TW = $clog2(TICK_N);

  logic [7:0] sys_q;
  logic [7:0] tick_q;
  logic [8:0] irq_q;
  logic ack_q;
  logic [31:0] rdat_q;
  lpm_state_t state_q;
  lpm_mode_t entry_mode_q;
  lpm_pwr_t pwr_q;
  logic [`LPM_PC_W-1:0] pc_q;
  logic vec_q;
  logic tset_q;
  logic [TICK_N-1:0] tsync1_q;
  logic [TICK_N-1:0] tsync2_q;
  logic tprev_q;

  logic bus_req;
  logic wr;
  logic tick_cur;
  logic tick_fall;
  logic req_any;
  logic enter_go;
  logic wdt_block;
  logic halt_wake;
  logic gated_vec;
  lpm_mode_t mode_now;
  lpm_state_t state_d;

  function automatic logic [1:0] reg_index(input logic [`LPM_ADR_W-1:0] a);
    unique case (a)
      `LPM_OFF_SYS: reg_index = 2'h0;
      `LPM_OFF_TICK: reg_index = 2'h1;
      `LPM_OFF_IRQ: reg_index = 2'h2;
      default: reg_index = 2'h3;
    endcase
  endfunction

  function automatic logic reg_hit(input logic [`LPM_ADR_W-1:0] a);
    reg_hit = (a == `LPM_OFF_SYS) || (a == `LPM_OFF_TICK) || (a == `LPM_OFF_IRQ) ||
              (a == `LPM_OFF_STAT);
  endfunction

  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = bus_req && wb_we_i;

  // Run mode from oscillator and clock select bits
  always_comb begin
    if (!sys_q[`LPM_BIT_CSEL]) begin
      mode_now = sys_q[`LPM_BIT_SOSC] ? LPM_DUAL_FAST : LPM_FAST_ONLY;
    end else begin
      mode_now = sys_q[`LPM_BIT_FOSC] ? LPM_SLOW_FAST_ON : LPM_SLOW_ONLY;
    end
  end

  // Tick source edge, both synchroniser stages before use
  assign tick_cur = tsync2_q[tick_q[TW-1:0]];
  assign tick_fall = tprev_q && !tick_cur;

  assign req_any = sys_q[`LPM_BIT_HALT] || sys_q[`LPM_BIT_GATE];
  assign wdt_block = (state_q == LPM_ST_RUN) && req_any && wdt_irq_i;
  assign enter_go = (state_q == LPM_ST_RUN) && req_any && !wdt_irq_i;
  assign halt_wake = |(irq_pend_i & irq_q[IRQ_N-1:0]);
  assign gated_vec = irq_q[`LPM_BIT_IMF] && irq_q[`LPM_TICK_IDX] &&
                     tick_q[`LPM_BIT_TEN];

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      LPM_ST_RUN: begin
        if (enter_go && sys_q[`LPM_BIT_GATE]) begin
          state_d = LPM_ST_GATED;
        end else if (enter_go) begin
          state_d = LPM_ST_HALT;
        end
      end
      LPM_ST_HALT: begin
        if (halt_wake) begin
          state_d = LPM_ST_RUN;
        end
      end
      LPM_ST_GATED: begin
        if (tick_fall) begin
          state_d = LPM_ST_RUN;
        end
      end
      default: state_d = LPM_ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= LPM_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Variant follows the run mode at request time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      entry_mode_q <= LPM_FAST_ONLY;
    end else if (enter_go) begin
      entry_mode_q <= mode_now;
    end
  end

  // System control register; software write wins over hardware clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_q <= `LPM_SYS_RST;
    end else if (wr && wb_sel_i[0] && reg_index(wb_adr_i) == 2'h0) begin
      sys_q <= wb_dat_i[7:0];
    end else if (wdt_block) begin
      sys_q[`LPM_BIT_HALT] <= 1'b0;
      sys_q[`LPM_BIT_GATE] <= 1'b0;
    end else if (state_q == LPM_ST_HALT && halt_wake) begin
      sys_q[`LPM_BIT_HALT] <= 1'b0;
    end else if (state_q == LPM_ST_GATED && tick_fall) begin
      sys_q[`LPM_BIT_GATE] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_q <= `LPM_TICK_RST;
    end else if (wr && wb_sel_i[0] && reg_index(wb_adr_i) == 2'h1) begin
      tick_q <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= `LPM_IRQ_RST;
    end else if (wr && reg_index(wb_adr_i) == 2'h2) begin
      if (wb_sel_i[0]) begin
        irq_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        irq_q[`LPM_BIT_IMF] <= wb_dat_i[`LPM_BIT_IMF];
      end
    end
  end

  // Wishbone answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req;
      rdat_q <= 32'h0000_0000;
      if (bus_req && !wb_we_i && reg_hit(wb_adr_i)) begin
        unique case (reg_index(wb_adr_i))
          2'h0: rdat_q[7:0] <= sys_q;
          2'h1: rdat_q[7:0] <= tick_q;
          2'h2: rdat_q[8:0] <= irq_q;
          default: rdat_q[3:0] <= {entry_mode_q, state_q};
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tsync1_q <= '0;
      tsync2_q <= '0;
      tprev_q <= 1'b0;
    end else begin
      tsync1_q <= tick_src_i;
      tsync2_q <= tsync1_q;
      tprev_q <= tick_cur;
    end
  end

  // Stall and peripheral clock controls follow the next state; tick clock enable stays on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_q <= '{cpu_stop: 1'b0, wdt_stop: 1'b0, periph_clk_en: 1'b1,
                 tick_clk_en: 1'b1, hold_state: 1'b0};
    end else begin
      pwr_q.cpu_stop <= (state_d != LPM_ST_RUN);
      pwr_q.wdt_stop <= (state_d != LPM_ST_RUN);
      pwr_q.periph_clk_en <= (state_d != LPM_ST_GATED);
      pwr_q.tick_clk_en <= 1'b1;
      pwr_q.hold_state <= (state_d != LPM_ST_RUN);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_q <= '0;
    end else if (enter_go) begin
      pc_q <= start_addr_i + `LPM_PC_ADV;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vec_q <= 1'b0;
      tset_q <= 1'b0;
    end else begin
      vec_q <= (state_q == LPM_ST_HALT && halt_wake && irq_q[`LPM_BIT_IMF]) ||
               (state_q == LPM_ST_GATED && tick_fall && gated_vec) ||
               wdt_block;
      tset_q <= enter_go && sys_q[`LPM_BIT_GATE] && tick_q[`LPM_BIT_TEN];
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign pwr_o = pwr_q;
  assign osc_o = '{fast_osc_en: sys_q[`LPM_BIT_FOSC], slow_osc_en: sys_q[`LPM_BIT_SOSC],
                   main_clk_sel: sys_q[`LPM_BIT_CSEL]};
  assign resume_pc_o = pc_q;
  assign vector_o = vec_q;
  assign tick_irq_set_o = tset_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_halt_stops_cpu: assert property (
    state_q == LPM_ST_HALT |-> pwr_o.cpu_stop && pwr_o.wdt_stop && pwr_o.periph_clk_en)
    else $error("cpu halt does not stop cpu and watchdog alone");
  a_gated_clocks: assert property (
    state_q == LPM_ST_GATED |-> !pwr_o.periph_clk_en && pwr_o.tick_clk_en)
    else $error("gated state clock enables wrong");
  a_hold_frozen: assert property (
    state_q != LPM_ST_RUN |-> pwr_o.hold_state)
    else $error("state not held while stopped");
  a_resume_pc: assert property (
    enter_go |=> resume_pc_o == $past(start_addr_i) + `LPM_PC_ADV && state_q != LPM_ST_RUN)
    else $error("held pc is not start plus two");
  a_halt_release: assert property (
    state_q == LPM_ST_HALT && halt_wake && !wr |=> state_q == LPM_ST_RUN &&
    !sys_q[`LPM_BIT_HALT] && osc_o == $past(osc_o))
    else $error("halt release did not clear request");
  a_reset_run: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> state_q == LPM_ST_RUN && !pwr_o.cpu_stop && osc_o.fast_osc_en &&
    !osc_o.main_clk_sel && !osc_o.slow_osc_en)
    else $error("reset does not restart in fast only run");
  a_halt_no_vector: assert property (
    state_q == LPM_ST_HALT && halt_wake && !irq_q[`LPM_BIT_IMF] |=> !vector_o)
    else $error("non vectoring halt wake raised vector");
  a_halt_vector: assert property (
    state_q == LPM_ST_HALT && halt_wake && irq_q[`LPM_BIT_IMF] |=> vector_o ##1 !vector_o)
    else $error("vectoring halt wake missed service");
  a_wdt_blocks: assert property (
    wdt_block |=> state_q == LPM_ST_RUN && vector_o ##1 state_q == LPM_ST_RUN)
    else $error("watchdog interrupt did not block entry");
  a_tick_latch: assert property (
    enter_go && sys_q[`LPM_BIT_GATE] |=> tick_irq_set_o == $past(tick_q[`LPM_BIT_TEN]))
    else $error("tick pending latch set wrong at gated entry");
  a_gated_exit: assert property (
    state_q == LPM_ST_GATED && tick_fall && !wr |=> state_q == LPM_ST_RUN &&
    !sys_q[`LPM_BIT_GATE] && vector_o == $past(gated_vec))
    else $error("gated release wrong");
  a_bus_ack: assert property (
    bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle");
  // Bus side checks
  a_read_idle: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside acknowledge");
  a_ack_from_req: assert property (
    wb_ack_o |-> $past(bus_req))
    else $error("acknowledge without a request");

  // Steady state, entry and release checks
  a_halt_stays: assert property (
    state_q == LPM_ST_HALT && !halt_wake |=> state_q == LPM_ST_HALT)
    else $error("cpu halt left without an enabled interrupt");
  a_gated_stays: assert property (
    state_q == LPM_ST_GATED && !tick_fall |=> state_q == LPM_ST_GATED)
    else $error("gated state left without a tick falling edge");
  a_halt_bit_held: assert property (
    state_q == LPM_ST_HALT && !halt_wake && !wr |=> $stable(sys_q[`LPM_BIT_HALT]))
    else $error("halt request changed while halted");
  a_gate_bit_held: assert property (
    state_q == LPM_ST_GATED && !tick_fall && !wr |=> $stable(sys_q[`LPM_BIT_GATE]))
    else $error("gate request changed while gated");
  a_gated_no_vector: assert property (
    state_q == LPM_ST_GATED && tick_fall && !gated_vec |=> !vector_o)
    else $error("non vectoring gated release raised vector");
  a_mode_capture: assert property (
    enter_go |=> entry_mode_q[1] == $past(sys_q[`LPM_BIT_CSEL]))
    else $error("captured run mode disagrees with clock select");
  a_halt_entry: assert property (
    enter_go && !sys_q[`LPM_BIT_GATE] |=> state_q == LPM_ST_HALT)
    else $error("halt request did not enter cpu halt");
  a_gated_entry: assert property (
    enter_go && sys_q[`LPM_BIT_GATE] |=> state_q == LPM_ST_GATED)
    else $error("gate request did not enter gated state");
  a_tick_set_gated: assert property (
    tick_irq_set_o |-> state_q == LPM_ST_GATED)
    else $error("tick latch set outside gated entry");
  a_wdt_no_entry: assert property (
    state_q == LPM_ST_RUN && wdt_irq_i |=> state_q == LPM_ST_RUN)
    else $error("state entered while watchdog interrupt pending");
  a_pc_held: assert property (
    state_q != LPM_ST_RUN |=> $stable(resume_pc_o))
    else $error("held pc changed while stopped");
  a_run_clocks: assert property (
    state_q == LPM_ST_RUN |-> !pwr_o.cpu_stop && !pwr_o.wdt_stop && pwr_o.periph_clk_en &&
    !pwr_o.hold_state)
    else $error("run state with stopped cpu or clocks");

  c_halt_wake: cover property (state_q == LPM_ST_HALT ##1 state_q == LPM_ST_RUN);
  c_gated_vec: cover property (state_q == LPM_ST_GATED && tick_fall && gated_vec);
  c_wdt_skip: cover property (wdt_block);
  c_slow_halt: cover property (enter_go && mode_now == LPM_SLOW_ONLY);
  c_gated_plain: cover property (state_q == LPM_ST_GATED && tick_fall && !gated_vec);

endmodule // lpm_ctrl

// File: logic/lpm_params.svh
// Constants of the low power mode controller
`ifndef LPM_PARAMS_SVH
`define LPM_PARAMS_SVH

`define LPM_ADR_W 8
`define LPM_OFF_SYS 8'h00
`define LPM_OFF_TICK 8'h04
`define LPM_OFF_IRQ 8'h08
`define LPM_OFF_STAT 8'h0C

`define LPM_BIT_FOSC 7
`define LPM_BIT_SOSC 6
`define LPM_BIT_CSEL 5
`define LPM_BIT_HALT 4
`define LPM_BIT_GATE 2
`define LPM_SYS_RST 8'h80

`define LPM_BIT_TEN 3
`define LPM_TSEL_W 3
`define LPM_TICK_RST 8'h00

`define LPM_IRQ_N 8
`define LPM_TICK_IDX 6
`define LPM_BIT_IMF 8
`define LPM_IRQ_RST 9'h000

`define LPM_PC_W 16
`define LPM_PC_ADV 16'h0002

`endif

// File: logic/lpm_pkg.sv
// Types of the low power mode controller
package lpm_pkg;

  typedef enum logic [1:0] {
    LPM_FAST_ONLY,
    LPM_DUAL_FAST,
    LPM_SLOW_FAST_ON,
    LPM_SLOW_ONLY
  } lpm_mode_t;

  typedef enum logic [1:0] {
    LPM_ST_RUN,
    LPM_ST_HALT,
    LPM_ST_GATED
  } lpm_state_t;

  typedef struct packed {
    logic cpu_stop;
    logic wdt_stop;
    logic periph_clk_en;
    logic tick_clk_en;
    logic hold_state;
  } lpm_pwr_t;

  typedef struct packed {
    logic fast_osc_en;
    logic slow_osc_en;
    logic main_clk_sel;
  } lpm_osc_t;

endpackage

// File: verif/lpm_irq_model.sv
// Interrupt latch and tick source model facing the mode controller
`timescale 1ns/1ps
module lpm_irq_model (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Reset, high
  input wire logic [7:0] set_i, // Raise latches
  input wire logic [7:0] clr_i, // Clear latches
  input wire logic tick_set_i, // Tick latch set pulse
  output logic [7:0] pend_o, // Pending latches
  output logic [7:0] tick_o // Tick source clocks
);
  logic [8:0] cnt_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 9'h000;
      pend_o <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 9'h001;
      pend_o <= (pend_o | set_i | {1'b0, tick_set_i, 6'h00}) & ~clr_i;
    end
  end
  // Source n toggles every 2^(n+1) cycles
  assign tick_o = cnt_q[8:1];
endmodule // lpm_irq_model

// File: verif/tb.sv
// Self-checking bench for the low power mode controller
`timescale 1ns/1ps
`include "lpm_params.svh"
module tb;
  import lpm_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, wdt, vec, tset;
  logic [7:0] adr, set, clr, pend, tick;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [15:0] start, rpc;
  lpm_pwr_t pwr;
  lpm_osc_t osc;
  int mismatches, check_count, vec_cnt, ts_cnt, cyc_cnt, v0, t0;
  logic [31:0] mv [4] = '{32'h80, 32'hC0, 32'hE0, 32'h60};
  lpm_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_pend_i(pend), .wdt_irq_i(wdt), .tick_src_i(tick),
    .start_addr_i(start), .pwr_o(pwr), .osc_o(osc), .resume_pc_o(rpc),
    .vector_o(vec), .tick_irq_set_o(tset));
  lpm_irq_model u_model (.clk_i(clk_i), .rst_i(rst_i), .set_i(set), .clr_i(clr),
    .tick_set_i(tset), .pend_o(pend), .tick_o(tick));
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    vec_cnt += (vec === 1'b1);
    ts_cnt += (tset === 1'b1);
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Pulse the latch set and clear controls for a cycle
  task automatic latch(input logic [7:0] s, input logic [7:0] c);
    set <= s;
    clr <= c;
    @(posedge clk_i);
    set <= 8'h00;
    clr <= 8'h00;
  endtask
  // Poll status until back in run
  task automatic wait_run();
    for (int n = 0; n < 400; n++) begin
      wb(1'b0, `LPM_OFF_STAT, 32'h0);
      if (q[1:0] === 2'b00) return;
    end
    chk(q, 32'hDEAD);
  endtask
  initial begin
    clk_i = 0; rst_i = 1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; wdat = 0;
    wdt = 0; set = 0; clr = 0; start = 16'h1234;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'(pwr), 32'h06);
    rd(`LPM_OFF_SYS, 32'h80);
    rd(`LPM_OFF_STAT, 32'h0);
    rd(8'h40, 32'h0);
    wb(1'b1, `LPM_OFF_IRQ, 32'h01);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, `LPM_OFF_SYS, mv[i]);
      chk(32'(osc), 32'(mv[i][7:5]));
      start <= 16'h1230 + 16'(i * 4);
      wb(1'b1, `LPM_OFF_SYS, mv[i] | 32'h10);
      repeat (2) @(posedge clk_i);
      chk(32'(pwr), 32'h1F);
      chk(32'(rpc), 32'h1232 + i * 4);
      rd(`LPM_OFF_STAT, 32'(i * 4 + 1));
      latch(8'h01, 8'h00);
      wait_run();
      rd(`LPM_OFF_SYS, mv[i]);
      chk(32'(pwr), 32'h06);
      latch(8'h00, 8'hFF);
    end
    chk(vec_cnt, 0);
    wb(1'b1, `LPM_OFF_IRQ, 32'h101);
    wb(1'b1, `LPM_OFF_SYS, 32'h70);
    repeat (2) @(posedge clk_i);
    latch(8'h01, 8'h00);
    wait_run();
    chk(vec_cnt, 1);
    latch(8'h00, 8'hFF);
    wdt <= 1'b1;
    wb(1'b1, `LPM_OFF_SYS, 32'h74);
    repeat (3) @(posedge clk_i);
    rd(`LPM_OFF_SYS, 32'h60);
    chk(vec_cnt, 2);
    chk(32'(pwr), 32'h06);
    wdt <= 1'b0;
    wb(1'b1, `LPM_OFF_IRQ, 32'h140);
    for (int j = 0; j < 2; j++) begin
      wb(1'b1, `LPM_OFF_TICK, j == 0 ? 32'h0F : 32'h07);
      v0 = vec_cnt;
      t0 = ts_cnt;
      @(posedge tick[7]);
      wb(1'b1, `LPM_OFF_SYS, 32'h64);
      repeat (2) @(posedge clk_i);
      chk(32'(pwr.periph_clk_en), 32'h0);
      chk(32'(pwr.tick_clk_en), 32'h1);
      chk(32'(rpc), 32'h123E);
      rd(`LPM_OFF_STAT, 32'h0E);
      wait_run();
      rd(`LPM_OFF_SYS, 32'h60);
      chk(ts_cnt - t0, j == 0);
      chk(vec_cnt - v0, j == 0);
      latch(8'h00, 8'hFF);
    end
    // Reset in mid halt restarts in fast only run
    wb(1'b1, `LPM_OFF_SYS, 32'h90);
    repeat (2) @(posedge clk_i);
    chk(32'(pwr), 32'h1F);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'(pwr), 32'h06);
    rd(`LPM_OFF_STAT, 32'h0);
    rd(`LPM_OFF_SYS, 32'h80);
    report_and_stop();
  end
endmodule // tb
